// >>> hdl/dhio_host_port.sv
// host transfer-instruction port of the flexible disk controller
module dhio_host_port (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // host i/o bus
    input wire logic io_strobe,
    input wire logic [11:0] io_instr,
    input wire logic [11:0] ac_in,
    input wire logic bus_init,
    output logic [11:0] ac_value,
    output logic ac_replace,
    output logic ac_or,
    output logic ac_clear,
    output logic skip,
    output logic irq,
    // compatibility mode strap pin, high for second mode
    input wire logic mode2_pin,
    // controller/drive subsystem
    output dhio_pkg::dhio_ctl_req_t ctl_req,
    output logic ctl_start,
    output logic ctl_init,
    input wire logic ctl_done,
    input wire logic ctl_error,
    input wire logic [11:0] ctl_status,
    // sector buffer word port
    output logic buf_wr,
    output logic buf_rd,
    output logic [11:0] buf_wdata,
    input wire logic [11:0] buf_rdata,
    // flag view
    output logic tr_flag,
    output logic err_flag,
    output logic done_flag,
    output logic int_enable
);

    logic op_valid;
    dhio_pkg::dhio_op_t op;
    logic do_lcd, do_xdr, do_str, do_ser, do_sdn, do_interrupt_control_op, do_init;
    logic [2:0] mode_sync_reg;
    logic mode2_reg;
    dhio_pkg::dhio_state_t state_reg;
    logic [11:0] cmd_reg;
    logic [11:0] iface_reg;
    logic [11:0] track_reg;
    logic [8:0] cnt_reg;
    logic go_reg;
    logic init_pend_reg;
    logic tr_set_reg, done_set_reg, err_set_reg;
    logic wlen8;
    logic [2:0] func;
    logic [8:0] words_base;
    logic [8:0] words_needed;
    logic last_word;
    logic clear_all;

    dhio_iot_decode u_decode (
        .io_strobe(io_strobe),
        .io_instr(io_instr),
        .op_valid(op_valid),
        .op(op)
    );

    // one strobe per operation, none for no operation
    assign do_lcd = op_valid && (op == dhio_pkg::load_command_op);
    assign do_xdr = op_valid && (op == dhio_pkg::transfer_data_op);
    assign do_str = op_valid && (op == dhio_pkg::skip_on_request_op);
    assign do_ser = op_valid && (op == dhio_pkg::skip_on_error_op);
    assign do_sdn = op_valid && (op == dhio_pkg::skip_on_done_op);
    assign do_interrupt_control_op = op_valid && (op == dhio_pkg::interrupt_control_op);
    assign do_init = op_valid && (op == dhio_pkg::op_initialize);
    assign clear_all = bus_init || do_init;

    // command fields; bit 4 has no reader
    assign wlen8 = cmd_reg[dhio_pkg::CMD_WLEN_BIT];
    assign func = cmd_reg[dhio_pkg::CMD_FUNC_MSB:dhio_pkg::CMD_FUNC_LSB];

    // word count, doubled for double density in second mode
    assign words_base = wlen8 ? dhio_pkg::WORDS_8BIT : dhio_pkg::WORDS_12BIT;
    assign words_needed = (mode2_reg && cmd_reg[dhio_pkg::CMD_DEN_BIT]) ?
                          {words_base[7:0], 1'b0} : words_base;
    assign last_word = (cnt_reg == 9'(words_needed - 9'h001));

    // strap pin: a change counts once the last two stages agree
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mode_sync_reg <= 3'h0;
            mode2_reg <= 1'b0;
        end else begin
            mode_sync_reg <= {mode_sync_reg[1:0], mode2_pin};
            if (mode_sync_reg[1] == mode_sync_reg[2]) begin
                mode2_reg <= mode_sync_reg[2];
            end
        end
    end

    // protocol sequencer; the interface register changes meaning per step
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_reg <= dhio_pkg::st_idle;
            cmd_reg <= dhio_pkg::RESET_WORD;
            iface_reg <= dhio_pkg::RESET_WORD;
            track_reg <= dhio_pkg::RESET_WORD;
            cnt_reg <= 9'h000;
            go_reg <= 1'b0;
            init_pend_reg <= 1'b0;
            tr_set_reg <= 1'b0;
            done_set_reg <= 1'b0;
            err_set_reg <= 1'b0;
            ctl_start <= 1'b0;
            ctl_init <= 1'b0;
            ctl_req <= '0;
            buf_wr <= 1'b0;
            buf_rd <= 1'b0;
            buf_wdata <= dhio_pkg::RESET_WORD;
        end else begin
            go_reg <= 1'b0;
            tr_set_reg <= 1'b0;
            done_set_reg <= 1'b0;
            err_set_reg <= 1'b0;
            ctl_start <= 1'b0;
            ctl_init <= 1'b0;
            buf_wr <= 1'b0;
            buf_rd <= 1'b0;
            if (clear_all) begin
                // seek, self-test and buffer reload run in the subsystem
                state_reg <= dhio_pkg::st_busy;
                init_pend_reg <= 1'b1;
                ctl_init <= 1'b1;
            end else if (do_lcd) begin
                cmd_reg <= ac_in;
                iface_reg <= ac_in;
                state_reg <= dhio_pkg::st_idle;
                if (mode2_reg && ac_in[dhio_pkg::CMD_WLEN_BIT]) begin
                    // upper four bits follow by transfer data
                    tr_set_reg <= 1'b1;
                    state_reg <= dhio_pkg::st_cmd_upper;
                end else begin
                    go_reg <= 1'b1; // whole command in one word
                end
            end else begin
                case (state_reg)
                    dhio_pkg::st_idle: begin
                        if (go_reg) begin
                            cnt_reg <= 9'h000;
                            ctl_req.func <= func;
                            ctl_req.drive <= cmd_reg[dhio_pkg::CMD_DRIVE_BIT];
                            ctl_req.density <= cmd_reg[dhio_pkg::CMD_DEN_BIT];
                            ctl_req.wlen8 <= wlen8;
                            ctl_req.mode2 <= mode2_reg;
                            case (func)
                                dhio_pkg::FN_FILL: begin
                                    tr_set_reg <= 1'b1;
                                    state_reg <= dhio_pkg::st_fill;
                                end
                                dhio_pkg::FN_EMPTY: begin
                                    buf_rd <= 1'b1;
                                    state_reg <= dhio_pkg::st_empty_wait;
                                end
                                dhio_pkg::FN_WRITE, dhio_pkg::FN_READ,
                                dhio_pkg::FN_WRDEL: begin
                                    tr_set_reg <= 1'b1; // ask for track
                                    state_reg <= dhio_pkg::st_track;
                                end
                                dhio_pkg::FN_AUX: begin
                                    if (mode2_reg) begin
                                        ctl_start <= 1'b1;
                                        state_reg <= dhio_pkg::st_busy;
                                    end else begin
                                        // first mode: clears init done and sets done, no subsystem start
                                        iface_reg <= dhio_pkg::RESET_WORD;
                                        done_set_reg <= 1'b1;
                                    end
                                end
                                default: begin
                                    ctl_start <= 1'b1;
                                    state_reg <= dhio_pkg::st_busy;
                                end
                            endcase
                        end
                    end
                    dhio_pkg::st_cmd_upper: begin
                        if (do_xdr) begin
                            cmd_reg[11:dhio_pkg::CMD_UPPER_LSB] <=
                                ac_in[11:dhio_pkg::CMD_UPPER_LSB];
                            go_reg <= 1'b1;
                            state_reg <= dhio_pkg::st_idle;
                        end
                    end
                    dhio_pkg::st_track: begin
                        if (do_xdr) begin
                            track_reg <= ac_in;
                            tr_set_reg <= 1'b1;
                            state_reg <= dhio_pkg::st_sector;
                        end
                    end
                    dhio_pkg::st_sector: begin
                        if (do_xdr) begin
                            if (track_reg > dhio_pkg::TRACK_MAX ||
                                ac_in < dhio_pkg::SECTOR_MIN ||
                                ac_in > dhio_pkg::SECTOR_MAX) begin
                                // bad address ends the function
                                iface_reg <= ctl_status;
                                err_set_reg <= 1'b1;
                                done_set_reg <= 1'b1;
                                state_reg <= dhio_pkg::st_idle;
                            end else begin
                                ctl_req.track <= track_reg[6:0];
                                ctl_req.sector <= ac_in[4:0];
                                ctl_start <= 1'b1;
                                state_reg <= dhio_pkg::st_busy;
                            end
                        end
                    end
                    dhio_pkg::st_fill: begin
                        if (do_xdr) begin
                            // eight-bit words sit in bits 4 to 11
                            buf_wr <= 1'b1;
                            buf_wdata <= wlen8 ? {4'h0, ac_in[7:0]} : ac_in;
                            cnt_reg <= cnt_reg + 9'h001;
                            if (last_word) begin
                                iface_reg <= ctl_status;
                                done_set_reg <= 1'b1;
                                state_reg <= dhio_pkg::st_idle;
                            end else begin
                                tr_set_reg <= 1'b1;
                            end
                        end
                    end
                    dhio_pkg::st_empty_wait: begin
                        // buffer word stands during the read pulse; latched on the edge that ends it
                        iface_reg <= buf_rdata;
                        tr_set_reg <= 1'b1;
                        state_reg <= dhio_pkg::st_empty_hold;
                    end
                    dhio_pkg::st_empty_hold: begin
                        if (do_xdr) begin
                            cnt_reg <= cnt_reg + 9'h001;
                            if (last_word) begin
                                iface_reg <= ctl_status;
                                done_set_reg <= 1'b1;
                                state_reg <= dhio_pkg::st_idle;
                            end else begin
                                buf_rd <= 1'b1;
                                state_reg <= dhio_pkg::st_empty_wait;
                            end
                        end
                    end
                    dhio_pkg::st_busy: begin
                        if (ctl_done) begin
                            // density mismatch arrives as ctl_error
                            iface_reg <= init_pend_reg ?
                                dhio_pkg::INIT_DONE_WORD : ctl_status;
                            init_pend_reg <= 1'b0;
                            err_set_reg <= ctl_error;
                            done_set_reg <= 1'b1;
                            state_reg <= dhio_pkg::st_idle;
                        end
                    end
                    default: state_reg <= dhio_pkg::st_idle;
                endcase
            end
        end
    end

    // answers to the host accumulator and skip line
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ac_value <= dhio_pkg::RESET_WORD;
            ac_replace <= 1'b0;
            ac_or <= 1'b0;
            ac_clear <= 1'b0;
            skip <= 1'b0;
        end else begin
            ac_replace <= 1'b0;
            ac_or <= 1'b0;
            ac_clear <= do_lcd;
            skip <= (do_str && tr_flag) || (do_ser && err_flag) ||
                    (do_sdn && done_flag);
            if (do_xdr) begin
                if (done_flag) begin
                    ac_value <= iface_reg; // status word
                    ac_replace <= 1'b1;
                end else if (state_reg == dhio_pkg::st_empty_hold) begin
                    if (wlen8) begin
                        ac_value <= {4'h0, iface_reg[7:0]};
                        ac_or <= 1'b1;
                    end else begin
                        ac_value <= iface_reg;
                        ac_replace <= 1'b1;
                    end
                end
                // other steps take from the accumulator and leave it
            end
        end
    end

    // flags: clear-all wins over a set in the same cycle; a set wins over a skip's clear
    always_ff @(posedge sys_clk) begin
        if (sys_rst || clear_all) begin
            tr_flag <= 1'b0;
            err_flag <= 1'b0;
            done_flag <= 1'b0;
            int_enable <= 1'b0;
            irq <= 1'b0;
        end else begin
            tr_flag <= tr_set_reg || (tr_flag && !do_str);
            err_flag <= err_set_reg || (err_flag && !do_ser);
            done_flag <= done_set_reg || (done_flag && !do_sdn);
            if (do_interrupt_control_op) begin
                int_enable <= ac_in[dhio_pkg::AC_IE_BIT];
            end
            // request only when done first rises with enable set
            if (done_set_reg && !done_flag && int_enable) begin
                irq <= 1'b1;
            end else if (do_sdn || !int_enable) begin
                irq <= 1'b0;
            end
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    lcd_clears_ac_a: assert property (do_lcd |=> ac_clear)
        else $error("load command did not clear accumulator");

    str_skip_a: assert property (do_str && tr_flag && !clear_all
        |=> skip && tr_flag == $past(tr_set_reg))
        else $error("skip on request wrong");

    error_with_done_a: assert property (err_set_reg |-> done_set_reg ##1
        (err_flag && done_flag))
        else $error("error set without done");

    sdn_skip_a: assert property (do_sdn && done_flag && !clear_all
        |=> skip && done_flag == $past(done_set_reg))
        else $error("skip on done wrong");

    interrupt_control_op_enable_a: assert property (do_interrupt_control_op && !clear_all
        |=> int_enable == $past(ac_in[0]))
        else $error("interrupt enable not taken from bit 11");

    init_clears_ie_a: assert property (clear_all
        |=> !int_enable && !irq && !done_flag ##1 ctl_init == 1'b0)
        else $error("initialize left enable set");

    eight_bit_or_a: assert property (do_xdr && !done_flag && wlen8 &&
        state_reg == dhio_pkg::st_empty_hold
        |=> ac_or && !ac_replace && ac_value[11:8] == 4'h0)
        else $error("eight-bit word not ORed");

    track_range_a: assert property (do_xdr && !do_lcd && !clear_all &&
        state_reg == dhio_pkg::st_sector && track_reg > dhio_pkg::TRACK_MAX
        |=> err_set_reg ##1 err_flag)
        else $error("bad track not flagged");

    status_return_a: assert property (do_xdr && done_flag
        |=> ac_replace && ac_value == $past(iface_reg))
        else $error("status word not returned");

endmodule // dhio_host_port

// >>> hdl/dhio_pkg.sv
// constants, types and field layout for the disk host transfer-instruction port
// How it works
// - decode eight 67x0 to 67x7 codes, middle digit ignored, into eight operations
// - load command copies accumulator into interface register, then clears accumulator
// - transfer data moves one word; direction from function, length from bit 5
// - while done is false, each transfer data acknowledges one word
// - from accumulator leaves it alone; to accumulator replaces twelve or ORs eight
// - after done, transfer data returns the error/status word to accumulator
// - skip on request skips when request flag set, then clears it
// - skip on error skips and clears error; error always sets done too
// - skip on done skips when done set, then clears done
// - interrupt control copies accumulator bit 11; interrupt when done rises enabled
// - interrupt enable cleared by clear-all, bus initialize and programmed initialize
// - initialize seeks, self-tests, reloads buffer, leaves only initialize-done bit 9
// - one physical interface register stands for six logical registers by step
// - first mode needs only one load command; command bit 4 ignored
// - command bit 5 clear selects twelve-bit words, set selects eight-bit
// - command bit 7 selects drive 1; fill and empty ignore it
// - second mode density bit requests density; mismatch reported as error
// - command bits 8-10 encode the eight functions
// - track address 0 to 76 given by transfer data for sector functions
// - sector address 1 to 26 given by transfer data for sector functions
// - data passes the buffer word; eight-bit words use bits 4 to 11
// - fill/empty ask 128 or 64 words, doubled at second-mode double density
package dhio_pkg;

    // device select prefix, octal 67 in the upper two digits
    localparam logic [5:0] DEV_PREFIX = 6'h37;

    // command field positions (bit 0 of the host word is the msb)
    localparam int CMD_UPPER_LSB = 8;
    localparam int CMD_DEN_BIT = 8;
    localparam int CMD_WLEN_BIT = 6;
    localparam int CMD_DRIVE_BIT = 4;
    localparam int CMD_FUNC_MSB = 3;
    localparam int CMD_FUNC_LSB = 1;
    localparam int AC_IE_BIT = 0;

    // function codes
    localparam logic [2:0] FN_FILL = 3'h0;
    localparam logic [2:0] FN_EMPTY = 3'h1;
    localparam logic [2:0] FN_WRITE = 3'h2;
    localparam logic [2:0] FN_READ = 3'h3;
    localparam logic [2:0] FN_AUX = 3'h4;
    localparam logic [2:0] FN_STATUS = 3'h5;
    localparam logic [2:0] FN_WRDEL = 3'h6;
    localparam logic [2:0] FN_ERRREG = 3'h7;

    // word counts and address limits
    localparam logic [8:0] WORDS_8BIT = 9'h080;
    localparam logic [8:0] WORDS_12BIT = 9'h040;
    localparam logic [11:0] TRACK_MAX = 12'h04C;
    localparam logic [11:0] SECTOR_MIN = 12'h001;
    localparam logic [11:0] SECTOR_MAX = 12'h01A;

    // status word after initialize: only initialize-done set
    localparam logic [11:0] INIT_DONE_WORD = 12'h004;
    localparam logic [11:0] RESET_WORD = 12'h000;

    // transfer instruction operations, low octal digit
    typedef enum logic [2:0] {
        op_no_operation,
        load_command_op,
        transfer_data_op,
        skip_on_request_op,
        skip_on_error_op,
        skip_on_done_op,
        interrupt_control_op,
        op_initialize
    } dhio_op_t;

    // protocol step, also which logical register the interface holds
    typedef enum logic [2:0] {
        st_idle,
        st_cmd_upper,
        st_track,
        st_sector,
        st_fill,
        st_empty_wait,
        st_empty_hold,
        st_busy
    } dhio_state_t;

    // request handed to the controller/drive subsystem
    typedef struct packed {
        logic [2:0] func;
        logic drive;
        logic density;
        logic wlen8;
        logic mode2;
        logic [6:0] track;
        logic [4:0] sector;
    } dhio_ctl_req_t;

endpackage : dhio_pkg

// >>> hdl/dhio_iot_decode.sv
// decoder for the disk port's transfer instructions
module dhio_iot_decode (
    // instruction from the host bus
    input wire logic io_strobe,
    input wire logic [11:0] io_instr,
    // decoded operation
    output logic op_valid,
    output dhio_pkg::dhio_op_t op
);

    // middle octal digit is a don't care
    assign op_valid = io_strobe && (io_instr[11:6] == dhio_pkg::DEV_PREFIX);
    assign op = dhio_pkg::dhio_op_t'(io_instr[2:0]);

endmodule // dhio_iot_decode

// >>> bench/dhio_ctl_model.sv
// behavioural controller/drive subsystem behind the disk port
module dhio_ctl_model (
    // clock
    input wire logic sys_clk,
    // requests from the port
    input wire logic ctl_start,
    input wire logic ctl_init,
    input wire logic buf_wr,
    input wire logic buf_rd,
    input wire logic [11:0] buf_wdata,
    // scenario control: end the next function with an error
    input wire logic fail_next,
    // answers
    output logic ctl_done = 1'b0,
    output logic ctl_error = 1'b0,
    output logic [11:0] ctl_status = 12'h000,
    output logic [11:0] buf_rdata,
    output logic [11:0] last_wr = 12'h000
);
    timeunit 1ns;
    timeprecision 1ns;
    int busy_cnt = 0;
    logic init_q = 1'b0;
    logic [11:0] rd_q;
    logic [7:0] rd_n = 8'h00;
    // each function ends after a fixed delay, like a short seek
    always @(posedge sys_clk) begin
        ctl_done <= 1'b0;
        if (ctl_start || ctl_init) begin
            busy_cnt <= 12;
            init_q <= ctl_init;
        end else if (busy_cnt == 1) begin
            busy_cnt <= 0;
            ctl_done <= 1'b1;
            ctl_error <= fail_next && !init_q;
            ctl_status <= init_q ? 12'h004 : 12'h001;
        end else if (busy_cnt > 1) begin
            busy_cnt <= busy_cnt - 1;
        end
    end
    // buffer word port: the port latches the word on the edge that ends
    // its read pulse, so the word must stand while the pulse does
    always @(posedge sys_clk) begin
        if (buf_rd) begin
            rd_n <= rd_n + 8'h01;
        end
        if (buf_wr) begin
            last_wr <= buf_wdata;
        end
    end
    // outside the pulse the word is inverted so it never looks valid
    assign rd_q = 12'hA50 ^ {4'h0, rd_n};
    assign buf_rdata = buf_rd ? rd_q : ~rd_q;
endmodule // dhio_ctl_model

// >>> bench/disk_host_iot_interface_tb_top.sv
// self-checking bench for the disk host transfer-instruction port
module disk_host_iot_interface_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic io_strobe = 1'b0;
    logic [11:0] io_instr = 12'h000;
    logic [11:0] ac_in = 12'h000;
    logic bus_init = 1'b0;
    logic fail_next = 1'b0;
    logic mode2_pin = 1'b0;
    logic [11:0] ac_value, ctl_status, buf_rdata, buf_wdata, last_wr, got;
    logic ac_replace, ac_or, ac_clear, skip, irq, ctl_start, ctl_init;
    logic ctl_done, ctl_error, buf_wr, buf_rd;
    logic tr_flag, err_flag, done_flag, int_enable;
    logic [3:0] seen;
    dhio_pkg::dhio_ctl_req_t ctl_req;
    int n_errors = 0;
    int n_tests = 0;
    always #25 sys_clk = ~sys_clk;
    dhio_host_port dut (.sys_clk, .sys_rst, .io_strobe, .io_instr, .ac_in,
        .bus_init, .ac_value, .ac_replace, .ac_or, .ac_clear, .skip, .irq,
        .mode2_pin, .ctl_req, .ctl_start, .ctl_init, .ctl_done,
        .ctl_error, .ctl_status, .buf_wr, .buf_rd, .buf_wdata, .buf_rdata,
        .tr_flag, .err_flag, .done_flag, .int_enable);
    dhio_ctl_model ctl (.sys_clk, .ctl_start, .ctl_init, .buf_wr, .buf_rd,
        .buf_wdata, .fail_next, .ctl_done, .ctl_error, .ctl_status,
        .buf_rdata, .last_wr);
    task automatic check(string w, logic [11:0] s, logic [11:0] e);
        n_tests++;
        if (s !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, s);
        end
    endtask
    task automatic chk1(string w, logic s, logic e);
        check(w, {11'h0, s}, {11'h0, e});
    endtask
    // one instruction, middle digit nonzero; gather answer pulses
    task automatic iot(logic [2:0] op, logic [11:0] ac, logic [5:0] dv = 6'h37);
        io_strobe = 1'b1;
        io_instr = {dv, 3'h5, op};
        ac_in = ac;
        @(posedge sys_clk) #1;
        io_strobe = 1'b0;
        seen = 4'h0;
        repeat (3) begin
            seen |= {ac_replace, ac_or, ac_clear, skip};
            if (ac_replace || ac_or) got = ac_value;
            @(posedge sys_clk) #1;
        end
    endtask
    // bounded wait for done (d=1) or transfer request (d=0)
    task automatic wait_flag(bit d);
        int k;
        k = 0;
        while (((d ? done_flag : tr_flag) !== 1'b1) && k < 400) begin
            @(posedge sys_clk) #1;
            k++;
        end
        chk1("flag wait", d ? done_flag : tr_flag, 1'b1);
    endtask
    // request, skip on request, then move one word
    task automatic word(logic [11:0] ac);
        wait_flag(1'b0);
        iot(3'h3, 12'h000);
        chk1("str skip", seen[0], 1'b1);
        chk1("tr clear", tr_flag, 1'b0);
        iot(3'h2, ac);
    endtask
    task automatic final_report();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        #2000000;
        n_errors++;
        final_report();
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        #1 sys_rst = 1'b0;
        repeat (4) @(posedge sys_clk) #1;
        iot(3'h7, 12'h000);
        wait_flag(1'b1);
        iot(3'h5, 12'h000, 6'h36);
        chk1("other prefix", seen[0], 1'b0);
        iot(3'h2, 12'h000);
        check("init status", got, dhio_pkg::INIT_DONE_WORD);
        iot(3'h5, 12'h000);
        chk1("sdn skip", seen[0], 1'b1);
        chk1("done clear", done_flag, 1'b0);
        iot(3'h6, 12'h001);
        chk1("ie set", int_enable, 1'b1);
        // fill, twelve-bit words in the first mode
        iot(3'h1, 12'h000);
        chk1("lcd clear", seen[1], 1'b1);
        for (int i = 0; i < 64; i++) begin
            chk1("early done", done_flag, 1'b0);
            word(12'h900 + 12'(i));
            check("fill ac", {8'h0, seen[3:2], 2'h0}, 12'h000);
            check("fill word", last_wr, 12'h900 + 12'(i));
        end
        wait_flag(1'b1);
        chk1("irq", irq, 1'b1);
        iot(3'h5, 12'h000);
        chk1("irq clear", irq, 1'b0);
        // empty, eight-bit words are OR-ed into the accumulator
        iot(3'h1, 12'h042);
        for (int i = 0; i < 128; i++) begin
            chk1("early done", done_flag, 1'b0);
            word(12'h000);
            chk1("or pulse", seen[2], 1'b1);
            check("empty word", got, {4'h0, 8'h50 ^ 8'(i)});
        end
        wait_flag(1'b1);
        iot(3'h5, 12'h000);
        // read at the last track and sector, drive 1, ending in error
        fail_next = 1'b1;
        iot(3'h1, 12'h016);
        word(12'h04C);
        word(12'h01A);
        wait_flag(1'b1);
        check("req track", {5'h0, ctl_req.track}, 12'h04C);
        check("req sector", {7'h0, ctl_req.sector}, 12'h01A);
        check("req func", {9'h0, ctl_req.func}, 12'h003);
        chk1("req drive", ctl_req.drive, 1'b1);
        chk1("err flag", err_flag, 1'b1);
        iot(3'h4, 12'h000);
        chk1("ser skip", seen[0], 1'b1);
        iot(3'h4, 12'h000);
        chk1("ser again", seen[0], 1'b0);
        // a track past the last one ends the read at once with error
        fail_next = 1'b0;
        iot(3'h5, 12'h000);
        iot(3'h1, 12'h006);
        word(12'h04D);
        word(12'h001);
        wait_flag(1'b1);
        chk1("bad track", err_flag, 1'b1);
        iot(3'h4, 12'h000);
        chk1("bad track skip", seen[0], 1'b1);
        // bus initialize drops the enable and the flags; strap to mode two
        mode2_pin = 1'b1;
        bus_init = 1'b1;
        @(posedge sys_clk) #1;
        bus_init = 1'b0;
        repeat (2) @(posedge sys_clk) #1;
        chk1("ie off", int_enable, 1'b0);
        chk1("done off", done_flag, 1'b0);
        wait_flag(1'b1);
        chk1("no irq", irq, 1'b0);
        // second mode, eight-bit: upper command bits follow a request
        iot(3'h5, 12'h000);
        iot(3'h1, 12'h04A);
        word(12'h100);
        wait_flag(1'b1);
        check("m2 func", {9'h0, ctl_req.func}, 12'h005);
        chk1("m2 density", ctl_req.density, 1'b1);
        chk1("m2 wlen8", ctl_req.wlen8, 1'b1);
        chk1("m2 mode", ctl_req.mode2, 1'b1);
        final_report();
    end
endmodule // disk_host_iot_interface_tb_top
